// File: hdl/dio_pkg.sv
// constants, register map and types for the bus-controlled parallel digital port
// Contract
// - 48 lines in 6 bytes, each byte input or output independently.
// - output lines hold last written value until written again.
// - after power-up lines are high impedance first, then driven per stored setup.
// - stable output asserts only after lines are configured.
// - saved setup and output values reload on every reset or power-on; power-on here loads the factory setup instead.
// - bit and byte operations switch their byte's direction automatically.
// - programmable inversion per bit or per byte for bit and byte operations.
// - string transfers use only preconfigured string bytes, forming one word.
// - every string output write produces a data strobe pulse; here a write with no string output byte set gives none.
// - string format, inversion, strobe polarity and handshake separately selectable.
// - a data strobe can be issued on request without data.
// - pulse drives selected bits to logical on for programmed width, then back.
// - single and two dual address modes; lower address parses commands.
// - in dual modes upper address passes data straight to or from string bytes.
// - binary mode latches each character into next output byte, strobes when full.
// - up to 15 inputs watched for rising and/or falling edges as selected.
// - enabled event bit raises a service request.
// - monitor levels and changed inputs readable.
// - lock blocks configuration changes; factory default restores all settings; here a factory default write still applies while locked and clears the lock.
// - configuration settings read back for verification.
package dio_pkg;

   localparam logic [7:0] ADDR_MODE = 8'h00;
   localparam logic [7:0] ADDR_DIR = 8'h04;
   localparam logic [7:0] ADDR_BIT = 8'h08;
   localparam logic [7:0] ADDR_BYTE_WR = 8'h0c;
   localparam logic [7:0] ADDR_BYTE_RD = 8'h10;
   localparam logic [7:0] ADDR_POL = 8'h14;
   localparam logic [7:0] ADDR_STR_LO = 8'h18;
   localparam logic [7:0] ADDR_STR_HI = 8'h1c;
   localparam logic [7:0] ADDR_STR_FMT = 8'h20;
   localparam logic [7:0] ADDR_STROBE = 8'h24;
   localparam logic [7:0] ADDR_PULSE = 8'h28;
   localparam logic [7:0] ADDR_PULSE_W = 8'h2c;
   localparam logic [7:0] ADDR_UPPER = 8'h30;
   localparam logic [7:0] ADDR_TRANS = 8'h34;
   localparam logic [7:0] ADDR_EV_EN = 8'h38;
   localparam logic [7:0] ADDR_EVENT = 8'h3c;
   localparam logic [7:0] ADDR_COND = 8'h40;
   localparam logic [7:0] ADDR_STATUS = 8'h44;
   localparam logic [7:0] ADDR_STORE = 8'h48;

   localparam logic [2:0] NUM_BYTES = 3'h6;

   localparam int CLK_NS = 4;
   localparam int STROBE_NS = 100;
   localparam int HIZ_NS = 1000;
   localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
   localparam int HIZ_CYC = (HIZ_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [15:0] PULSE_W_DEFAULT = 16'h0032;

   typedef enum logic [1:0] {
      AMODE_SINGLE   = 2'b00,
      AMODE_DUAL_PRI = 2'b01,
      AMODE_DUAL_SEC = 2'b10
   } amode_t;

   typedef enum logic [1:0] {
      BITOP_NONE  = 2'b00,
      BITOP_SET   = 2'b01,
      BITOP_CLR   = 2'b10,
      BITOP_QUERY = 2'b11
   } bit_op_t;

   typedef enum logic [1:0] {
      ST_HIZ  = 2'b00,
      ST_LOAD = 2'b01,
      ST_RUN  = 2'b10
   } init_t;

   typedef struct packed {
      amode_t      amode;
      logic        binmode;
      logic        lock;
      logic [5:0]  dir;
      logic [5:0]  str_out;
      logic [5:0]  str_in;
      logic [47:0] latch;
      logic [47:0] pol;
      logic        str_inv;
      logic        strobe_pol;
      logic        hshake;
      logic        bit_rev;
      logic [15:0] pw;
      logic [14:0] rise;
      logic [14:0] fall;
      logic [14:0] ev_en;
   } cfg_t;

   localparam cfg_t FACTORY_CFG = '{
      amode: AMODE_SINGLE, binmode: 1'b0, lock: 1'b0, dir: 6'h00, str_out: 6'h00,
      str_in: 6'h00, latch: 48'h0, pol: 48'h0, str_inv: 1'b0, strobe_pol: 1'b0,
      hshake: 1'b0, bit_rev: 1'b0, pw: PULSE_W_DEFAULT, rise: 15'h0, fall: 15'h0,
      ev_en: 15'h0};

endpackage : dio_pkg

// File: hdl/edge_monitor.sv
// edge monitor: synchronises watched inputs and keeps sticky change flags
`timescale 1ns/1ps
module edge_monitor #(
   parameter int WIDTH = 15
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] sense,
   input  wire logic [WIDTH-1:0] rise_en,
   input  wire logic [WIDTH-1:0] fall_en,
   input  wire logic [WIDTH-1:0] clear,
   output logic      [WIDTH-1:0] events,
   output logic      [WIDTH-1:0] levels
);

   typedef struct packed {
      logic [WIDTH-1:0] sync1;
      logic [WIDTH-1:0] sync2;
      logic [WIDTH-1:0] prev;
      logic [WIDTH-1:0] evt;
      logic [1:0]       fill;
   } mon_t;

   mon_t r;
   mon_t n;
   logic [WIDTH-1:0] hit;

   always_comb begin
      n = r;
      n.sync1 = sense;
      n.sync2 = r.sync1;
      n.prev = r.sync2;
      // no edges until the pipeline holds real samples, or reset would look like a change
      if (r.fill != 2'h3) begin
         n.fill = r.fill + 2'h1;
      end
      hit = '0;
      if (r.fill == 2'h3) begin
         hit = (r.sync2 & ~r.prev & rise_en) | (~r.sync2 & r.prev & fall_en);
      end
      // a new edge wins over a clear in the same cycle
      n.evt = (r.evt & ~clear) | hit;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign events = r.evt;
   assign levels = r.sync2;

endmodule : edge_monitor

// File: hdl/parallel_dio.sv
// bus-controlled 48-line parallel digital port with string, pulse and monitor functions
//
// Added by the designer: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module parallel_dio (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        por,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic [47:0] io_in,
   output logic      [47:0] io_out,
   output logic      [47:0] io_oe,
   output logic             strobe,
   input  wire logic        hs_ack,
   output logic             stable,
   output logic             srq
);

   typedef struct packed {
      logic           ph_v;
      logic           ph_w;
      logic [7:0]     ph_a;
      logic           rd_wait;
      logic [31:0]    rdata;
      dio_pkg::cfg_t  cur;
      dio_pkg::cfg_t  saved;
      dio_pkg::init_t st;
      logic [7:0]     icnt;
      logic [5:0]     bit_sel;
      logic [2:0]     byte_sel;
      logic [2:0]     pol_sel;
      logic [15:0]    str_hi;
      logic [47:0]    pmask;
      logic [15:0]    pcnt;
      logic           pend;
      logic [7:0]     scnt;
      logic [2:0]     bin_idx;
      logic [47:0]    pins;
      logic [47:0]    oe;
      logic           strobe_pin;
      logic           stable;
   } state_t;

   state_t      r;
   state_t      n;
   state_t      rst_val;
   logic [31:0] rd_mux;
   logic [31:0] d;
   logic        wr;
   logic        cfg_ok;
   logic        save;
   logic [14:0] ev_clr;
   logic [14:0] mon_event;
   logic [14:0] mon_level;
   logic [47:0] in_word;
   logic [47:0] in_logic;
   logic [47:0] bin_byte;
   logic [2:0]  bsel;
   logic [2:0]  bin_pos;
   logic [2:0]  bin_cnt;

   // one enable bit per byte widened to eight line enables
   function automatic logic [47:0] expand(input logic [5:0] m);
      logic [47:0] v;
      v = '0;
      for (int k = 0; k < 6; k++) begin
         v[k*8 +: 8] = {8{m[k]}};
      end
      return v;
   endfunction : expand

   // spread consecutive word bytes over the bytes selected by the mask
   function automatic logic [47:0] scatter(input logic [47:0] w, input logic [5:0] m);
      logic [47:0] v;
      int          j;
      v = '0;
      j = 0;
      for (int k = 0; k < 6; k++) begin
         if (m[k]) begin
            v[k*8 +: 8] = w[j*8 +: 8];
            j++;
         end
      end
      return v;
   endfunction : scatter

   // collect the bytes selected by the mask into consecutive word bytes
   function automatic logic [47:0] gather(input logic [47:0] p, input logic [5:0] m);
      logic [47:0] v;
      int          j;
      v = '0;
      j = 0;
      for (int k = 0; k < 6; k++) begin
         if (m[k]) begin
            v[j*8 +: 8] = p[k*8 +: 8];
            j++;
         end
      end
      return v;
   endfunction : gather

   // string data format: optional bit reversal within each byte, optional inversion
   function automatic logic [47:0] fmt(input logic [47:0] w, input logic inv,
                                       input logic rev);
      logic [47:0] v;
      logic [7:0]  b;
      v = '0;
      for (int k = 0; k < 6; k++) begin
         b = w[k*8 +: 8];
         if (rev) begin
            b = {<<{b}};
         end
         v[k*8 +: 8] = b ^ {8{inv}};
      end
      return v;
   endfunction : fmt

   edge_monitor #(
      .WIDTH (15)
   ) u_monitor (
      .clk     (clk),
      .rst     (rst),
      .sense   (io_in[14:0]),
      .rise_en (r.cur.rise),
      .fall_en (r.cur.fall),
      .clear   (ev_clr),
      .events  (mon_event),
      .levels  (mon_level)
   );

   assign wr = r.ph_v && r.ph_w;
   assign d = hwdata;
   assign cfg_ok = !r.cur.lock;
   assign in_logic = io_in ^ r.cur.pol;
   assign in_word = fmt(gather(io_in, r.cur.str_in), r.cur.str_inv, r.cur.bit_rev);
   assign ev_clr = (wr && r.ph_a == dio_pkg::ADDR_EVENT) ? d[14:0] : 15'h0;
   assign bsel = d[2:0];
   assign bin_byte = fmt({40'h0, d[7:0]}, r.cur.str_inv, r.cur.bit_rev);

   // binary mode: position of the next string output byte, and how many there are
   always_comb begin
      bin_pos = 3'h0;
      bin_cnt = 3'h0;
      for (int k = 0; k < 6; k++) begin
         if (r.cur.str_out[k]) begin
            if (bin_cnt == r.bin_idx) begin
               bin_pos = 3'(k);
            end
            bin_cnt = bin_cnt + 3'h1;
         end
      end
   end

   // reset reloads the saved setup; power-on replaces it with the factory setup
   always_comb begin
      rst_val = '0;
      rst_val.st = dio_pkg::ST_HIZ;
      rst_val.saved = por ? dio_pkg::FACTORY_CFG : r.saved;
      rst_val.cur = rst_val.saved;
      rst_val.pins = rst_val.cur.pol;
      rst_val.strobe_pin = rst_val.cur.strobe_pol;
   end

   always_comb begin
      rd_mux = 32'h0;
      if (r.ph_a == dio_pkg::ADDR_MODE) begin
         rd_mux = {28'h0, r.cur.lock, r.cur.binmode, r.cur.amode};
      end else if (r.ph_a == dio_pkg::ADDR_DIR) begin
         rd_mux = {10'h0, r.cur.str_in, 2'h0, r.cur.str_out, 2'h0, r.cur.dir};
      end else if (r.ph_a == dio_pkg::ADDR_BIT) begin
         rd_mux = {22'h0, r.bit_sel, 3'h0, in_logic[r.bit_sel]};
      end else if (r.ph_a == dio_pkg::ADDR_BYTE_WR) begin
         rd_mux = {24'h0, r.cur.latch[r.byte_sel*8 +: 8]};
      end else if (r.ph_a == dio_pkg::ADDR_BYTE_RD) begin
         rd_mux = {24'h0, in_logic[r.byte_sel*8 +: 8]};
      end else if (r.ph_a == dio_pkg::ADDR_POL) begin
         rd_mux = {16'h0, r.cur.pol[r.pol_sel*8 +: 8], 5'h0, r.pol_sel};
      end else if (r.ph_a == dio_pkg::ADDR_STR_LO) begin
         rd_mux = in_word[31:0];
      end else if (r.ph_a == dio_pkg::ADDR_STR_HI) begin
         rd_mux = {16'h0, in_word[47:32]};
      end else if (r.ph_a == dio_pkg::ADDR_STR_FMT) begin
         rd_mux = {28'h0, r.cur.bit_rev, r.cur.hshake, r.cur.strobe_pol, r.cur.str_inv};
      end else if (r.ph_a == dio_pkg::ADDR_PULSE) begin
         rd_mux = {31'h0, r.pcnt != 16'h0};
      end else if (r.ph_a == dio_pkg::ADDR_PULSE_W) begin
         rd_mux = {16'h0, r.cur.pw};
      end else if (r.ph_a == dio_pkg::ADDR_UPPER) begin
         if (r.cur.amode != dio_pkg::AMODE_SINGLE) begin
            rd_mux = in_word[31:0];
         end
      end else if (r.ph_a == dio_pkg::ADDR_TRANS) begin
         rd_mux = {1'b0, r.cur.fall, 1'b0, r.cur.rise};
      end else if (r.ph_a == dio_pkg::ADDR_EV_EN) begin
         rd_mux = {17'h0, r.cur.ev_en};
      end else if (r.ph_a == dio_pkg::ADDR_EVENT) begin
         rd_mux = {17'h0, mon_event};
      end else if (r.ph_a == dio_pkg::ADDR_COND) begin
         rd_mux = {17'h0, mon_level};
      end else if (r.ph_a == dio_pkg::ADDR_STATUS) begin
         rd_mux = {28'h0, r.pend || r.scnt != 8'h0, r.pcnt != 16'h0, srq, r.stable};
      end
   end

   always_comb begin
      n = r;
      save = 1'b0;

      // bus side: reads take one wait state so that a write just before is visible
      if (hready) begin
         n.ph_v = hsel && htrans[1];
         n.ph_w = hwrite;
         n.ph_a = haddr[7:0];
         n.rd_wait = 1'b0;
      end
      if (r.ph_v && !r.ph_w && !r.rd_wait) begin
         n.rd_wait = 1'b1;
         n.rdata = rd_mux;
      end

      // power-up sequencing
      case (r.st)
         dio_pkg::ST_HIZ: begin
            n.icnt = r.icnt + 8'h1;
            if (r.icnt == 8'(dio_pkg::HIZ_CYC - 1)) begin
               n.st = dio_pkg::ST_LOAD;
            end
         end
         dio_pkg::ST_LOAD: begin
            n.st = dio_pkg::ST_RUN;
         end
         default: begin
            n.st = dio_pkg::ST_RUN;
         end
      endcase

      // pulse width timer
      if (r.pcnt > 16'h1) begin
         n.pcnt = r.pcnt - 16'h1;
      end else if (r.pcnt == 16'h1) begin
         n.pcnt = 16'h0;
         n.pmask = '0;
      end

      // strobe starts one cycle after the data so every byte is already settled
      if (r.pend) begin
         n.pend = 1'b0;
         n.scnt = 8'(dio_pkg::STROBE_CYC);
      end else if (r.scnt > 8'h1) begin
         n.scnt = r.scnt - 8'h1;
      end else if (r.scnt == 8'h1 && (!r.cur.hshake || hs_ack)) begin
         n.scnt = 8'h0;
      end

      if (wr) begin
         if (r.ph_a == dio_pkg::ADDR_MODE) begin
            n.cur.lock = d[3];
            if (cfg_ok && d[1:0] != 2'b11) begin
               n.cur.amode = dio_pkg::amode_t'(d[1:0]);
               n.cur.binmode = d[2];
               n.bin_idx = 3'h0;
            end
         end else if (r.ph_a == dio_pkg::ADDR_DIR) begin
            if (cfg_ok) begin
               n.cur.dir = d[5:0];
               n.cur.str_out = d[13:8];
               n.cur.str_in = d[21:16];
               n.bin_idx = 3'h0;
            end
         end else if (r.ph_a == dio_pkg::ADDR_BIT) begin
            // a line index names its byte in bits 5:3, not in the low bits
            if (d[5:3] < dio_pkg::NUM_BYTES) begin
               n.bit_sel = d[5:0];
               case (dio_pkg::bit_op_t'(d[9:8]))
                  dio_pkg::BITOP_SET: begin
                     n.cur.latch[d[5:0]] = 1'b1;
                     n.cur.dir[d[5:3]] = 1'b1;
                  end
                  dio_pkg::BITOP_CLR: begin
                     n.cur.latch[d[5:0]] = 1'b0;
                     n.cur.dir[d[5:3]] = 1'b1;
                  end
                  dio_pkg::BITOP_QUERY: begin
                     n.cur.dir[d[5:3]] = 1'b0;
                  end
                  default: begin
                     n.bit_sel = d[5:0];
                  end
               endcase
            end
         end else if (r.ph_a == dio_pkg::ADDR_BYTE_WR) begin
            if (bsel < dio_pkg::NUM_BYTES) begin
               n.byte_sel = bsel;
               n.cur.latch[bsel*8 +: 8] = d[15:8];
               n.cur.dir[bsel] = 1'b1;
            end
         end else if (r.ph_a == dio_pkg::ADDR_BYTE_RD) begin
            if (bsel < dio_pkg::NUM_BYTES) begin
               n.byte_sel = bsel;
               n.cur.dir[bsel] = 1'b0;
            end
         end else if (r.ph_a == dio_pkg::ADDR_POL) begin
            if (bsel < dio_pkg::NUM_BYTES) begin
               n.pol_sel = bsel;
               if (cfg_ok) begin
                  n.cur.pol[bsel*8 +: 8] = d[15:8];
               end
            end
         end else if (r.ph_a == dio_pkg::ADDR_STR_HI) begin
            n.str_hi = d[15:0];
         end else if (r.ph_a == dio_pkg::ADDR_STR_LO ||
                      (r.ph_a == dio_pkg::ADDR_UPPER &&
                       r.cur.amode != dio_pkg::AMODE_SINGLE && !r.cur.binmode)) begin
            if (r.cur.str_out != 6'h0) begin
               n.cur.latch = (r.cur.latch & ~expand(r.cur.str_out)) |
                             scatter(fmt({r.str_hi, d}, r.cur.str_inv, r.cur.bit_rev),
                                     r.cur.str_out);
               n.pend = 1'b1;
            end
         end else if (r.ph_a == dio_pkg::ADDR_UPPER) begin
            if (r.cur.amode != dio_pkg::AMODE_SINGLE && bin_cnt != 3'h0) begin
               n.cur.latch[bin_pos*8 +: 8] = bin_byte[7:0];
               if (r.bin_idx == bin_cnt - 3'h1) begin
                  n.bin_idx = 3'h0;
                  n.pend = 1'b1;
               end else begin
                  n.bin_idx = r.bin_idx + 3'h1;
               end
            end
         end else if (r.ph_a == dio_pkg::ADDR_STR_FMT) begin
            if (cfg_ok) begin
               n.cur.str_inv = d[0];
               n.cur.strobe_pol = d[1];
               n.cur.hshake = d[2];
               n.cur.bit_rev = d[3];
            end
         end else if (r.ph_a == dio_pkg::ADDR_STROBE) begin
            if (d[0]) begin
               n.pend = 1'b1;
            end
         end else if (r.ph_a == dio_pkg::ADDR_PULSE) begin
            if (bsel < dio_pkg::NUM_BYTES && d[15:8] != 8'h0) begin
               n.pmask[bsel*8 +: 8] = n.pmask[bsel*8 +: 8] | d[15:8];
               n.cur.dir[bsel] = 1'b1;
               n.pcnt = (r.cur.pw == 16'h0) ? 16'h1 : r.cur.pw;
            end
         end else if (r.ph_a == dio_pkg::ADDR_PULSE_W) begin
            if (cfg_ok) begin
               n.cur.pw = d[15:0];
            end
         end else if (r.ph_a == dio_pkg::ADDR_TRANS) begin
            if (cfg_ok) begin
               n.cur.rise = d[14:0];
               n.cur.fall = d[30:16];
            end
         end else if (r.ph_a == dio_pkg::ADDR_EV_EN) begin
            if (cfg_ok) begin
               n.cur.ev_en = d[14:0];
            end
         end else if (r.ph_a == dio_pkg::ADDR_STORE) begin
            if (d[1]) begin
               n.cur = dio_pkg::FACTORY_CFG;
               n.saved = dio_pkg::FACTORY_CFG;
               n.bin_idx = 3'h0;
            end else if (d[0]) begin
               save = 1'b1;
            end
         end
      end

      // a save takes the setup as it stands after this cycle's write
      if (save) begin
         n.saved = n.cur;
      end

      // pins: pulsed bits sit at their logical on level, polarity applied last
      n.pins = (n.cur.latch | n.pmask) ^ n.cur.pol;
      n.oe = (n.st == dio_pkg::ST_HIZ) ? 48'h0 : expand(n.cur.dir);
      n.strobe_pin = (n.scnt != 8'h0) ^ n.cur.strobe_pol;
      n.stable = (n.st == dio_pkg::ST_RUN);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         r <= rst_val;
      end else begin
         r <= n;
      end
   end

   assign hrdata = r.rdata;
   assign hreadyout = !(r.ph_v && !r.ph_w && !r.rd_wait);
   assign hresp = 1'b0;
   assign io_out = r.pins;
   assign io_oe = r.oe;
   assign strobe = r.strobe_pin;
   assign stable = r.stable;
   assign srq = |(mon_event & r.cur.ev_en);

endmodule : parallel_dio

// File: tb/parallel_dio_assertions.sv
// checker for bus timing, power-up order, strobe and event behaviour of the port
`timescale 1ns/1ps
module parallel_dio_assertions (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [47:0] io_in,
   input wire logic [47:0] io_oe,
   input wire logic        strobe,
   input wire logic        stable,
   input wire logic        srq
);
   logic [8:0] hiz_cnt;
   logic       wr_d;
   // saturating count of edges since reset release
   always_ff @(posedge clk) begin
      hiz_cnt <= rst ? 9'h0 : hiz_cnt + {8'h0, hiz_cnt != 9'h1ff};
      wr_d    <= !rst && hsel && hready && htrans[1] && hwrite;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence rd_taken; hsel && hready && htrans[1] && !hwrite; endsequence
   sequence wr_taken; hsel && hready && htrans[1] && hwrite; endsequence
   sequence str_taken; wr_taken ##0 haddr[7:0] == dio_pkg::ADDR_STR_LO; endsequence
   chk_resp_okay: assert property (hresp == 1'b0)
      else $error("bus response not okay");
   chk_read_wait: assert property (rd_taken |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   chk_write_nowait: assert property (wr_taken |=> hreadyout)
      else $error("write stalled");
   chk_oe_late: assert property (io_oe != 48'h0 |-> hiz_cnt >= 9'd250)
      else $error("lines driven during high impedance phase");
   chk_stable_late: assert property (stable |-> hiz_cnt >= 9'd251)
      else $error("stable too early");
   chk_oe_cause: assert property ($changed(io_oe) |-> $past(wr_d)
      || hiz_cnt inside {[9'd250:9'd252]}) else $error("direction changed unasked");
   chk_strobe_after: assert property (str_taken |-> ##3 $changed(strobe))
      else $error("no strobe after word write");
   chk_srq_cause: assert property ($rose(srq) |-> $past(wr_d)
      || $past(io_in[14:0], 2) != $past(io_in[14:0], 5)) else $error("service request unasked");
endmodule : parallel_dio_assertions

// File: tb/far_side.sv
// far-side model: pulled-up lines, external drivers and a strobe acknowledger
`timescale 1ns/1ps
module far_side (
   input  wire logic        clk,
   input  wire logic [47:0] io_out,
   input  wire logic [47:0] io_oe,
   input  wire logic [47:0] ext_en,
   input  wire logic [47:0] ext_val,
   input  wire logic        strobe,
   input  wire logic [7:0]  ack_delay,
   output logic      [47:0] io_in,
   output logic             hs_ack
);
   logic [7:0] wait_cnt = 8'h0;
   // lines nobody drives float high through the pull-ups
   assign io_in = (io_oe & io_out) | (~io_oe & ((ext_en & ext_val) | ~ext_en));
   // acknowledges only once the strobe has stood high for ack_delay cycles
   always_ff @(posedge clk) begin
      wait_cnt <= strobe ? wait_cnt + {7'h0, wait_cnt != ack_delay} : 8'h0;
   end
   assign hs_ack = strobe && wait_cnt == ack_delay;
endmodule : far_side

// File: tb/tb_top.sv
// self-checking bench for the parallel digital port
`timescale 1ns/1ps
module tb_top;
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic [2:0]  sel;
      logic [7:0]  exp_out;
      logic [7:0]  exp_oe;
   } row_t;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        por = 1'b1;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [47:0] ext_en = 48'h0;
   logic [47:0] ext_val = 48'h0;
   logic [7:0]  ack_delay = 8'h28;
   logic [31:0] hrdata, rdata;
   logic [47:0] io_in, io_out, io_oe;
   logic        hreadyout, hresp, strobe, hs_ack, stable, srq;
   int          fails = 0;
   int          checks_done = 0;
   int          n, len;
   row_t        rows [6] = '{
      '{dio_pkg::ADDR_BYTE_WR, 32'h3c00, 3'h0, 8'h3c, 8'hff},
      '{dio_pkg::ADDR_BYTE_WR, 32'ha505, 3'h5, 8'ha5, 8'hff},
      '{dio_pkg::ADDR_BIT, 32'h010a, 3'h1, 8'h04, 8'hff},
      '{dio_pkg::ADDR_POL, 32'hff00, 3'h0, 8'hc3, 8'hff},
      '{dio_pkg::ADDR_BIT, 32'h020a, 3'h1, 8'h00, 8'hff},
      '{dio_pkg::ADDR_BYTE_RD, 32'h0001, 3'h1, 8'h00, 8'h00}};
   parallel_dio i_dut (.*, .hready(hreadyout), .hsize(3'h2));
   far_side i_far (.*);
   initial begin
      forever #2 clk = ~clk;
   end
   task automatic conclude;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : conclude
   task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic wait_ready;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 64);
      if (hreadyout !== 1'b1) begin
         fails++;
         conclude();
      end
   endtask : wait_ready
   // called just after a rising edge; returns at the edge that ends the data phase
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr  <= {24'h0, a};
      wait_ready();
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready();
      rdata = hrdata;
   endtask : bus
   task automatic wait_stable;
      for (n = 0; n < 400 && stable !== 1'b1; n++) @(posedge clk);
      chk(stable, 48'h1, "stable");
   endtask : wait_stable
   // counts the cycles that the strobe or pulsed line 41 stands high
   task automatic span(input logic sel);
      len = 0;
      for (n = 0; n < 64 && (sel ? io_out[41] : strobe) !== 1'b1; n++) @(posedge clk);
      while ((sel ? io_out[41] : strobe) === 1'b1 && len < 300) begin
         @(posedge clk);
         len++;
      end
   endtask : span
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      por <= 1'b0;
      wait_stable();
      foreach (rows[i]) begin
         bus(1'b1, rows[i].addr, rows[i].wdata);
         @(posedge clk);
         chk(io_out[rows[i].sel*8 +: 8], rows[i].exp_out, "drive");
         chk(io_oe[rows[i].sel*8 +: 8], rows[i].exp_oe, "direction");
      end
      $display("table done");
      ext_en[15:8] <= 8'hff;
      ext_val[15:8] <= 8'h5a;
      repeat (3) @(posedge clk);
      bus(1'b0, dio_pkg::ADDR_BYTE_RD, 32'h0);
      chk(rdata[7:0], 48'h5a, "byte read");
      bus(1'b0, 8'h4c, 32'h0);
      chk(rdata, 48'h0, "unmapped");
      bus(1'b1, dio_pkg::ADDR_DIR, 32'h020c2d);
      bus(1'b1, dio_pkg::ADDR_MODE, 32'h8);
      bus(1'b1, dio_pkg::ADDR_DIR, 32'h0);
      bus(1'b0, dio_pkg::ADDR_DIR, 32'h0);
      chk(rdata[21:0], 48'h020c2d, "locked dir");
      bus(1'b0, dio_pkg::ADDR_STR_LO, 32'h0);
      chk(rdata, 48'h5a, "string read");
      bus(1'b1, dio_pkg::ADDR_MODE, 32'h0);
      bus(1'b1, dio_pkg::ADDR_STR_HI, 32'h0);
      bus(1'b1, dio_pkg::ADDR_STR_LO, 32'h1234abcd);
      span(1'b0);
      chk(48'(len), 48'(dio_pkg::STROBE_CYC), "strobe width");
      chk(io_out[31:16], 48'habcd, "word");
      bus(1'b1, dio_pkg::ADDR_STR_FMT, 32'h4);
      bus(1'b1, dio_pkg::ADDR_STR_LO, 32'h5678);
      span(1'b0);
      chk(len >= 40, 48'h1, "handshake hold");
      bus(1'b1, dio_pkg::ADDR_STR_FMT, 32'h0);
      bus(1'b1, dio_pkg::ADDR_STROBE, 32'h1);
      span(1'b0);
      chk(48'(len), 48'(dio_pkg::STROBE_CYC), "manual strobe");
      bus(1'b1, dio_pkg::ADDR_PULSE_W, 32'h5);
      bus(1'b1, dio_pkg::ADDR_PULSE, 32'h0205);
      span(1'b1);
      chk(48'(len), 48'h5, "pulse width");
      chk(io_out[47:40], 48'ha5, "after pulse");
      $display("string and pulse done");
      bus(1'b1, dio_pkg::ADDR_DIR, 32'h0c2c);
      ext_en[3] <= 1'b1;
      repeat (8) @(posedge clk);
      bus(1'b1, dio_pkg::ADDR_TRANS, 32'h8);
      bus(1'b1, dio_pkg::ADDR_EV_EN, 32'h8);
      ext_val[3] <= 1'b1;
      for (n = 0; n < 8 && srq !== 1'b1; n++) @(posedge clk);
      chk(srq, 48'h1, "rise event");
      bus(1'b0, dio_pkg::ADDR_EVENT, 32'h0);
      chk(rdata[14:0], 48'h8, "event flags");
      bus(1'b1, dio_pkg::ADDR_EVENT, 32'h8);
      ext_val[3] <= 1'b0;
      repeat (8) @(posedge clk);
      chk(srq, 48'h0, "fall ignored");
      bus(1'b1, dio_pkg::ADDR_STORE, 32'h1);
      bus(1'b1, dio_pkg::ADDR_BYTE_WR, 32'h0005);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      wait_stable();
      chk(io_out[47:40], 48'ha5, "reload");
      $display("monitor and reload done");
      conclude();
   end
endmodule : tb_top
bind parallel_dio parallel_dio_assertions i_chk (.*);
